// ===== shared/sesb_cfg.svh
/*
  Constants of the sticky error status bank: offsets, field positions,
  reset values and per-bit masking classes.
  Assumes inclusion by bare name from design files.
*/
`ifndef SESB_CFG_SVH
`define SESB_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SESB_ADDR_ID 8'h3F
`define SESB_ADDR_ZONES 8'h40
`define SESB_ADDR_VOLT_LO 8'h41
`define SESB_ADDR_VOLT_HI 8'h42

// ----------------------------------------------------------------
// identification fields
// ----------------------------------------------------------------
`define SESB_STEP_LSB 0
`define SESB_VER_LSB 4

// ----------------------------------------------------------------
// status layout, 24 bits: 42h in [23:16], 41h in [15:8], 40h in [7:0]
// ----------------------------------------------------------------
`define SESB_STATUS_RESET 8'h00
`define SESB_IMPL_MASK 24'hF1471F
`define SESB_SLEEP_ALWAYS 24'h414710
`define SESB_SLEEP_OPTION 24'h300003
`define SESB_REGULATOR_BIT 4
`define SESB_READ_IDLE 8'h00

`endif

// ===== shared/sesb_pkg.sv
/*
  Types of the sticky error status bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sesb_pkg;

  // ----------------------------------------------------------------
  // system sleep state as reported by the host
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SESB_S0 = 2'h0,
    SESB_S1 = 2'h1,
    SESB_S3 = 2'h2,
    SESB_S45 = 2'h3
  } sesb_sleep_t;

  localparam int unsigned SESB_NUM_REGS = 3;
  localparam int unsigned SESB_FLAGS = 8 * SESB_NUM_REGS;

endpackage

// ===== logic/sesb_flag_cell.sv
/*
  One sticky error flag.
  Assumes condition and mask from logic on the same clock.
*/
`timescale 1ns/1ns

module sesb_flag_cell #(
  parameter bit IMPLEMENTED = 1'b1
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // event side
  input wire logic cond_in,
  input wire logic masked_in,
  // software clear
  input wire logic clear_in,
  // state
  output logic flag_out
);

  logic active;
  logic next_flag;

  // ----------------------------------------------------------------
  // next value
  // ----------------------------------------------------------------
  always_comb begin
    active = cond_in & ~masked_in;
    // set beats clear; an unmasked live condition holds the flag
    next_flag = IMPLEMENTED & (active | (flag_out & ~clear_in)); // see R2 // see R6 // see R7 // see R8 // see R15
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= next_flag;
    end
  end

endmodule // sesb_flag_cell

// ===== logic/sesb_bank.sv
/*
  Sticky error status bank with identification register and summary alert.
  Assumes a register port driven by a serial front end on the same clock,
  limit comparators on the same clock, and an asynchronous regulator-hot pin.
*/
`timescale 1ns/1ns
`include "sesb_cfg.svh"

// Behaviour
// R1: the identification register is read-only, stepping in [3:0], version in [7:4].
// R2: a monitored error event sets its status flag.
// R3: the summary error flag is set whenever any status flag is set.
// R4: with alert enabled, the alert output asserts whenever the summary flag is set.
// R5: processor-hot fixed-threshold flags never reach the summary flag or alert.
// R6: a set flag stays set after its cause goes away until software clears it.
// R7: a clear has no effect while the cause persists and the error is unmasked.
// R8: a masked error's flag clears on request even with the cause present.
// R9: in ASF mode a read or a write of ones clears flags; otherwise only a write of ones.
// R10: the host reports sleep state, and events are masked in their listed sleep states.
// R11: register 40h bits 0-3 flag zones 1-4; zones 1-2 optionally sleep-masked, 3-4 never.
// R12: register 40h bit 4 flags regulator-hot, masked in S3 and S4/5; bits 7:5 reserved.
// R13: register 41h bits 0-2 flag analog inputs 1-3 and bit 6 input 7, all sleep-masked.
// R14: register 42h bit 0 flags input 9, bits 4-7 inputs 13-16 with mixed sleep masking.
// R15: reserved status bits read as zero and ignore writes.
module sesb_bank #(
  parameter int unsigned VERSION_ID = 4'hA,  // arbitrary value
  parameter int unsigned STEPPING_ID = 4'h3  // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // mode and masking
  input wire logic asf_mode_in,
  input wire logic alert_enable_in,
  input wire sesb_pkg::sesb_sleep_t sleep_state_in,
  input wire logic [23:0] error_mask_in,
  input wire logic [23:0] sleep_option_mask_in,
  // error events
  input wire logic [3:0] zone_out_of_limit_in,
  input wire logic regulator_hot_input_in,
  input wire logic [2:0] analog_one_to_three_out_in,
  input wire logic analog_seven_out_in,
  input wire logic analog_nine_out_in,
  input wire logic [3:0] analog_thirteen_to_sixteen_out_in,
  // summary
  output logic error_summary_flag_out,
  output logic alert_n_out
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (VERSION_ID > 15 || STEPPING_ID > 15) begin : g_bad_id
    $error("identification fields are four bits wide");
  end

  localparam logic [7:0] ID_VALUE =
    8'((VERSION_ID << `SESB_VER_LSB) | (STEPPING_ID << `SESB_STEP_LSB));

  // ----------------------------------------------------------------
  // regulator-hot pin synchroniser
  // ----------------------------------------------------------------
  logic reg_hot_meta;
  logic reg_hot_sync;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_hot_meta <= 1'b0;
      reg_hot_sync <= 1'b0;
    end else begin
      reg_hot_meta <= regulator_hot_input_in;
      reg_hot_sync <= reg_hot_meta;
    end
  end

  // ----------------------------------------------------------------
  // condition and mask vectors
  // ----------------------------------------------------------------
  logic [23:0] cond;
  logic [23:0] sleep_mask;
  logic [23:0] masked;
  logic [23:0] clear;
  logic [23:0] flags;
  logic sleeping;

  always_comb begin
    cond = 24'h000000;
    cond[3:0] = zone_out_of_limit_in;  // see R11
    cond[`SESB_REGULATOR_BIT] = reg_hot_sync;  // see R12
    cond[10:8] = analog_one_to_three_out_in;  // see R13
    cond[14] = analog_seven_out_in;  // see R13
    cond[16] = analog_nine_out_in;  // see R14
    cond[23:20] = analog_thirteen_to_sixteen_out_in;  // see R14
    sleeping = (sleep_state_in == sesb_pkg::SESB_S3) ||
               (sleep_state_in == sesb_pkg::SESB_S45);
    // fixed classes plus host-selected optional ones
    sleep_mask = sleeping ?
      (`SESB_SLEEP_ALWAYS | (`SESB_SLEEP_OPTION & sleep_option_mask_in)) :
      24'h000000;  // see R10 // see R11 // see R12 // see R13 // see R14
    masked = error_mask_in | sleep_mask;
  end

  // ----------------------------------------------------------------
  // clear requests per status register
  // ----------------------------------------------------------------
  logic [2:0] hit;

  always_comb begin
    hit[0] = (reg_addr_in == `SESB_ADDR_ZONES);
    hit[1] = (reg_addr_in == `SESB_ADDR_VOLT_LO);
    hit[2] = (reg_addr_in == `SESB_ADDR_VOLT_HI);
  end

  for (genvar i = 0; i < 24; i++) begin : g_flag
    // write one clears; a read clears too in ASF mode
    assign clear[i] = hit[i / 8] &
                      ((reg_wr_in & reg_wdata_in[i % 8]) |
                       (asf_mode_in & reg_rd_in));  // see R9
    sesb_flag_cell #(
      .IMPLEMENTED(1'(`SESB_IMPL_MASK >> i))
    ) u_cell (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .cond_in(cond[i]),
      .masked_in(masked[i]),
      .clear_in(clear[i]),
      .flag_out(flags[i])
    );
  end

  // ----------------------------------------------------------------
  // read data, summary and alert
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic next_summary;
  logic next_alert_n;

  always_comb begin
    case (reg_addr_in)
      `SESB_ADDR_ID: next_rdata = ID_VALUE;  // see R1
      `SESB_ADDR_ZONES: next_rdata = flags[7:0];  // see R15
      `SESB_ADDR_VOLT_LO: next_rdata = flags[15:8];
      `SESB_ADDR_VOLT_HI: next_rdata = flags[23:16];
      default: next_rdata = `SESB_READ_IDLE;
    endcase
    if (!reg_rd_in) begin
      next_rdata = reg_rdata_out;
    end
    // only the three banks here feed the summary
    next_summary = |flags;  // see R3 // see R5
    next_alert_n = ~(alert_enable_in & error_summary_flag_out);  // see R4
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= `SESB_READ_IDLE;
      error_summary_flag_out <= 1'b0;
      alert_n_out <= 1'b1;
    end else begin
      reg_rdata_out <= next_rdata;
      error_summary_flag_out <= next_summary;
      alert_n_out <= next_alert_n;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_id_read;
    reg_rd_in && reg_addr_in == `SESB_ADDR_ID;
  endsequence

  sequence s_clear_live;
    reg_wr_in && hit[0] && reg_wdata_in[0] && zone_out_of_limit_in[0] && !masked[0];
  endsequence

  sequence s_clear_masked;
    reg_wr_in && hit[0] && reg_wdata_in[0] && masked[0] && !reg_rd_in;
  endsequence

  property p_id_read;
    s_id_read |=> reg_rdata_out == ID_VALUE;
  endproperty
  a_id_read: assert property (p_id_read) else $error("id read wrong");  // see R1

  property p_event_sets;
    (zone_out_of_limit_in[3] && !masked[3]) |=> flags[3];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event lost");  // see R2

  property p_summary;
    (|flags) |=> error_summary_flag_out;
  endproperty
  a_summary: assert property (p_summary) else $error("summary missed");  // see R3

  // enable is taken in the cycle the summary is seen, as the output register does
  property p_alert;
    (alert_enable_in && error_summary_flag_out) |=> !alert_n_out;
  endproperty
  a_alert: assert property (p_alert) else $error("alert missed");  // see R4

  property p_sticky;
    (flags[8] && !clear[8]) |=> flags[8];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");  // see R6

  property p_clear_live;
    s_clear_live |=> flags[0];
  endproperty
  a_clear_live: assert property (p_clear_live) else $error("live flag cleared");  // see R7

  property p_clear_masked;
    s_clear_masked |=> !flags[0];
  endproperty
  a_clear_masked: assert property (p_clear_masked) else $error("masked flag kept");  // see R8

  property p_read_keeps;
    (!asf_mode_in && reg_rd_in && !reg_wr_in) |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read cleared");  // see R9

  property p_asf_read_clears;
    (asf_mode_in && reg_rd_in && hit[1] && !(|(cond[15:8] & ~masked[15:8])))
      |=> flags[15:8] == 8'h00;
  endproperty
  a_asf_read_clears: assert property (p_asf_read_clears) else $error("asf read kept");  // see R9

  property p_sleep_mask;
    (sleeping && !flags[4]) |=> !flags[4];
  endproperty
  a_sleep_mask: assert property (p_sleep_mask) else $error("sleep mask ignored");  // see R10

  property p_reserved;
    (flags & ~`SESB_IMPL_MASK) == 24'h000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");  // see R15

endmodule // sesb_bank

// ===== verif/sesb_host.sv
/*
  Host model: byte reads and writes on the register port.
  Assumes the bank samples strobes on the rising clock edge.
*/
`timescale 1ns/1ns

module sesb_host (
  // clock
  input wire logic clk_sys_in,
  // register port
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end

  // ----------------------------------------------------------------
  // one-cycle strobes; released data shows its inverse
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
  endtask
endmodule // sesb_host

// ===== verif/tb.sv
/*
  Self-checking bench of the sticky error status bank.
  Assumes the host model and the bank on one 50 MHz clock.
*/
`timescale 1ns/1ns

module tb;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, summary, alert_n;
  logic asf = 1'b0;
  logic alert_en = 1'b1;
  sesb_pkg::sesb_sleep_t sleep = sesb_pkg::SESB_S0;
  logic [23:0] emask = 24'h000000;
  logic [23:0] omask = 24'h000000;
  logic [23:0] ev = 24'h000000;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h4C6D1433;
  int num_errors = 0;
  int n_tests = 0;

  initial forever #10 clk_sys_in = ~clk_sys_in;

  sesb_host u_host (.clk_sys_in(clk_sys_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_wdata_out(wdata), .reg_rd_out(rd));

  sesb_bank #(.VERSION_ID(4'hA), .STEPPING_ID(4'h3)) uut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .asf_mode_in(asf),
    .alert_enable_in(alert_en), .sleep_state_in(sleep), .error_mask_in(emask),
    .sleep_option_mask_in(omask), .zone_out_of_limit_in(ev[3:0]),
    .regulator_hot_input_in(ev[4]), .analog_one_to_three_out_in(ev[10:8]),
    .analog_seven_out_in(ev[14]), .analog_nine_out_in(ev[16]),
    .analog_thirteen_to_sixteen_out_in(ev[23:20]), .error_summary_flag_out(summary),
    .alert_n_out(alert_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic close_out;
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", what, e, s);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask

  task automatic pulse(input logic [23:0] v);
    @(posedge clk_sys_in);
    ev <= v;
    repeat (2) @(posedge clk_sys_in);
    ev <= 24'h000000;
    repeat (6) @(posedge clk_sys_in);
  endtask

  task automatic outs(input logic s, input logic a);
    check("summary", {7'h00, s}, {7'h00, summary});
    check("alert_n", {7'h00, a}, {7'h00, alert_n});
  endtask

  // read data monitor, one cycle after each read strobe
  always @(posedge clk_sys_in) begin
    if (rd_q) check("rdata", exp_q.pop_front(), rdata);
    rd_q <= rd;
  end

  initial begin
    #100000;
    num_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] x;
    logic en;
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_chk(8'h3F, 8'hA3);
    u_host.wr(8'h3F, 8'h00);
    rd_chk(8'h3F, 8'hA3);
    rd_chk(8'h55, 8'h00);
    rd_chk(8'h40, 8'h00);
    seed = xs(seed);
    x = {20'h00000, seed[3:0] | 4'h1};
    pulse(x);
    outs(1'b1, 1'b0);
    rd_chk(8'h40, x[7:0]);
    rd_chk(8'h40, x[7:0]);
    u_host.wr(8'h40, x[7:0]);
    rd_chk(8'h40, 8'h00);
    repeat (3) @(posedge clk_sys_in);
    outs(1'b0, 1'b1);
    // live unmasked cause blocks the clear, masking lets it through
    ev <= 24'h000004;
    repeat (3) @(posedge clk_sys_in);
    u_host.wr(8'h40, 8'h04);
    rd_chk(8'h40, 8'h04);
    emask <= 24'h000004;
    u_host.wr(8'h40, 8'h04);
    rd_chk(8'h40, 8'h00);
    ev <= 24'h000000;
    emask <= 24'h000000;
    // every sleep state, optional masking off and on
    for (int s = 0; s < 4; s++) begin
      for (int o = 0; o < 2; o++) begin
        en = ((s + o) % 2) == 1;
        sleep <= sesb_pkg::sesb_sleep_t'(s);
        omask <= (o == 1) ? 24'hFFFFFF : 24'h000000;
        alert_en <= en;
        x = 24'hF1471F;
        if (s >= 2) x &= ~(24'h414710 | ((o == 1) ? 24'h300003 : 24'h000000));
        pulse(24'hFFFFFF);
        outs(1'b1, ~en);
        rd_chk(8'h40, x[7:0]);
        rd_chk(8'h41, x[15:8]);
        rd_chk(8'h42, x[23:16]);
        for (int a = 0; a < 3; a++) u_host.wr(8'h40 + 8'(a), 8'hFF);
      end
    end
    // read-to-clear, one register at a time
    sleep <= sesb_pkg::SESB_S0;
    asf <= 1'b1;
    pulse(24'hFFFFFF);
    rd_chk(8'h41, 8'h47);
    rd_chk(8'h41, 8'h00);
    rd_chk(8'h42, 8'hF1);
    rd_chk(8'h40, 8'h1F);
    rd_chk(8'h40, 8'h00);
    repeat (3) @(posedge clk_sys_in);
    close_out();
  end
endmodule // tb
